// [rtl/i2crt_defines.vh]
/*
 * constants for the i2c register access target: address options,
 * bit counts and the read pointer bump position.
 * assumes inclusion by bare name from the target module.
 */
`ifndef I2CRT_DEFINES_VH
`define I2CRT_DEFINES_VH

// base of the six selectable 7-bit bus addresses (0001000 .. 0001101)
`define I2CRT_ADDR_BASE     7'h08
// number of selectable addresses
`define I2CRT_ADDR_OPTS     3'h6
// bits per byte on the wire
`define I2CRT_BYTE_BITS     4'h8
// scl rising edge of a read byte on which the pointer advances (1-based)
`define I2CRT_RD_BUMP_EDGE  4'h5
// pointer value after reset
`define I2CRT_PTR_RESET     8'h00

`endif

// [rtl/i2crt_target.v]
/*
 * i2c target front end giving a host access to an internal register file
 * through an auto-incrementing 8-bit register index pointer.
 * assumes scl/sda inputs already synchronous to i_clk (sampled directly),
 * the register file lives outside and answers o_reg_index combinationally
 * on i_rd_data, and open-drain sda is resolved by the surroundings.
 */
// Notes on behaviour
// [R1] write: address, register index, data, all acked
// [R2] host sends direction bit: one read, zero write
// [R3] index byte acked loads the pointer
// [R4] write data stored, pointer bumps at ack
// [R5] read byte bumps pointer at fifth scl
// [R6] read bump survives an early stop
// [R7] read byte uses pointer at byte start
// [R8] pointer kept across stop and other traffic
// [R9] host rewrites index before each repeated read
// [R10] single read: index write, restart, read byte
// [R11] burst read continues while host acks
// [R12] own address acked for both directions
// [R13] silent until bias rails good is high
// [R14] address picked from six values by select
// [R15] foreign address ignored, sda released, pointer kept
// [R16] eight-bit pointer, wraps to zero
`timescale 1ns/10ps
`include "i2crt_defines.vh"

module i2crt_target #(
    parameter PTR_W = 8                      // register index width
) (
    input  wire             i_clk,           // 40 mhz system clock
    input  wire             i_resetn,        // async active-low reset
    input  wire             i_bias_rails_good, // bias rails report good
    input  wire [2:0]       i_addr_sel,      // sensed address resistor code 0..5
    input  wire             i_scl,           // bus clock level
    input  wire             i_sda,           // bus data level
    input  wire [7:0]       i_rd_data,       // register contents at o_reg_index
    output reg              o_sda_oe,        // high: pull sda low
    output reg              o_sda_out,       // always zero when driven
    output reg  [PTR_W-1:0] o_reg_index,     // register index pointer
    output reg              o_wr_en,         // one-cycle write strobe
    output reg  [PTR_W-1:0] o_wr_addr,       // write target
    output reg  [7:0]       o_wr_data        // write data
);

    ////////////////////////////////////////////////////////////////////////
    // states
    localparam [2:0] ST_IDLE  = 3'h0;  // waiting for start
    localparam [2:0] ST_ADDR  = 3'h1;  // shifting in address byte
    localparam [2:0] ST_AACK  = 3'h2;  // address acknowledge slot
    localparam [2:0] ST_WBYTE = 3'h3;  // shifting in index or data
    localparam [2:0] ST_WACK  = 3'h4;  // write byte acknowledge slot
    localparam [2:0] ST_RBYTE = 3'h5;  // shifting out read byte
    localparam [2:0] ST_RACK  = 3'h6;  // host ack/nack of read byte

    // clamp select code into the six options and form the address
    function [6:0] own_addr;
        input [2:0] sel;
        begin
            if (sel < `I2CRT_ADDR_OPTS) begin
                own_addr = `I2CRT_ADDR_BASE + {4'h0, sel};
            end else begin
                // out of range code: treat as open resistor, top option
                own_addr = `I2CRT_ADDR_BASE + {4'h0, `I2CRT_ADDR_OPTS - 3'h1};
            end
        end
    endfunction

    // pointer step; plain width overflow rolls the top value back to zero
    function [PTR_W-1:0] ptr_next;
        input [PTR_W-1:0] ptr;
        begin
            ptr_next = ptr + {{(PTR_W-1){1'b0}}, 1'b1};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // line history and bus conditions
    reg        scl_d_r;                 // previous scl
    reg        sda_d_r;                 // previous sda
    reg        ready_r;                 // interface activated
    reg  [6:0] my_addr_r;               // address latched on activation
    reg  [2:0] state_r;                 // protocol state
    reg  [3:0] bit_cnt_r;               // bits seen this byte
    reg  [7:0] shift_r;                 // receive / transmit shifter
    reg        idx_phase_r;             // next write byte is the index
    reg        bumped_r;                // read bump done this byte

    wire scl_rise = i_scl & ~scl_d_r;
    wire scl_fall = ~i_scl & scl_d_r;
    // start/repeated start: sda falls while scl high
    wire start_c  = scl_d_r & i_scl & sda_d_r & ~i_sda;
    // stop: sda rises while scl high
    wire stop_c   = scl_d_r & i_scl & ~sda_d_r & i_sda;

    // history registers
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_d_r <= i_scl;
            sda_d_r <= i_sda;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // activation: address strapped once bias rails are good
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ready_r   <= 1'b0;
            my_addr_r <= `I2CRT_ADDR_BASE;
        end else if (!i_bias_rails_good) begin
            // [R13] held off
            ready_r   <= 1'b0;
        end else if (!ready_r) begin
            // [R14] address select
            ready_r   <= 1'b1;
            my_addr_r <= own_addr(i_addr_sel);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // protocol engine; pointer lives in o_reg_index and is never reset by
    // stop or start so it survives other targets' traffic
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_r     <= ST_IDLE;
            bit_cnt_r   <= 4'h0;
            shift_r     <= 8'h00;
            idx_phase_r <= 1'b0;
            bumped_r    <= 1'b0;
            o_sda_oe    <= 1'b0;
            o_sda_out   <= 1'b0;
            o_reg_index <= `I2CRT_PTR_RESET;
            o_wr_en     <= 1'b0;
            o_wr_addr   <= {PTR_W{1'b0}};
            o_wr_data   <= 8'h00;
        end else begin
            o_wr_en <= 1'b0;
            if (!ready_r) begin
                // [R13] released bus
                state_r  <= ST_IDLE;
                o_sda_oe <= 1'b0;
            end else if (start_c) begin
                // start or restart always re-reads the address
                state_r   <= ST_ADDR;
                bit_cnt_r <= 4'h0;
                o_sda_oe  <= 1'b0;
            end else if (stop_c) begin
                // [R6] bump already done, stop keeps it
                // [R8] pointer untouched here
                state_r  <= ST_IDLE;
                o_sda_oe <= 1'b0;
            end else begin
                case (state_r)
                ST_IDLE: begin
                    o_sda_oe <= 1'b0;
                end
                ST_ADDR, ST_WBYTE: begin
                    if (scl_rise) begin
                        shift_r   <= {shift_r[6:0], i_sda};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end else if (scl_fall && bit_cnt_r == `I2CRT_BYTE_BITS) begin
                        bit_cnt_r <= 4'h0;
                        if (state_r == ST_ADDR) begin
                            if (shift_r[7:1] == my_addr_r) begin
                                // [R12] ack own address
                                o_sda_oe <= 1'b1;
                                state_r  <= ST_AACK;
                            end else begin
                                // [R15] not ours, stay silent
                                state_r  <= ST_IDLE;
                            end
                        end else begin
                            // [R1] ack every written byte
                            o_sda_oe <= 1'b1;
                            state_r  <= ST_WACK;
                            if (idx_phase_r) begin
                                // [R3] load pointer
                                // [R16] full byte index
                                o_reg_index <= shift_r[PTR_W-1:0];
                                idx_phase_r <= 1'b0;
                            end else begin
                                // [R4] store and advance
                                o_wr_en     <= 1'b1;
                                o_wr_addr   <= o_reg_index;
                                o_wr_data   <= shift_r;
                                // [R16] natural wrap
                                o_reg_index <= ptr_next(o_reg_index);
                            end
                        end
                    end
                end
                ST_AACK: begin
                    if (scl_fall) begin
                        if (shift_r[0]) begin
                            // [R7] capture at byte start
                            // [R10] first data after address
                            shift_r   <= i_rd_data;
                            o_sda_oe  <= ~i_rd_data[7];
                            bumped_r  <= 1'b0;
                            state_r   <= ST_RBYTE;
                        end else begin
                            // first write byte is the index
                            o_sda_oe    <= 1'b0;
                            idx_phase_r <= 1'b1;
                            state_r     <= ST_WBYTE;
                        end
                    end
                end
                ST_WACK: begin
                    if (scl_fall) begin
                        o_sda_oe <= 1'b0;
                        state_r  <= ST_WBYTE;
                    end
                end
                ST_RBYTE: begin
                    if (scl_rise) begin
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                        if (bit_cnt_r + 4'h1 == `I2CRT_RD_BUMP_EDGE && !bumped_r) begin
                            // [R5] fifth scl bump
                            // [R16] natural wrap
                            o_reg_index <= ptr_next(o_reg_index);
                            bumped_r    <= 1'b1;
                        end
                    end else if (scl_fall) begin
                        if (bit_cnt_r == `I2CRT_BYTE_BITS) begin
                            bit_cnt_r <= 4'h0;
                            o_sda_oe  <= 1'b0;
                            state_r   <= ST_RACK;
                        end else begin
                            shift_r  <= {shift_r[6:0], 1'b0};
                            o_sda_oe <= ~shift_r[6];
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        // remember host answer in bit 0
                        shift_r[0] <= i_sda;
                    end else if (scl_fall) begin
                        if (!shift_r[0]) begin
                            // [R11] host ack: next register
                            shift_r  <= i_rd_data;
                            o_sda_oe <= ~i_rd_data[7];
                            bumped_r <= 1'b0;
                            state_r  <= ST_RBYTE;
                        end else begin
                            // nack: release and wait for stop
                            state_r <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_r  <= ST_IDLE;
                    o_sda_oe <= 1'b0;
                end
                endcase
            end
        end
    end

endmodule

// [tb/i2crt_target_sva.sv]
/* checker for the i2c target: sees only its ports, bound after the module.
   assumes one clock domain and an active-low asynchronous reset. */
`timescale 1ns/10ps
module i2crt_target_sva (
    input wire       i_clk,
    input wire       i_resetn,
    input wire       i_bias_rails_good,
    input wire       i_scl,
    input wire       o_sda_oe,
    input wire       o_sda_out,
    input wire [7:0] o_reg_index,
    input wire       o_wr_en,
    input wire [7:0] o_wr_addr
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    ////////////////////////////////////////////////////////////////////////////
    property p_quiet; !i_bias_rails_good [*3] |-> !o_sda_oe; endproperty
    a_quiet: assert property (p_quiet) else $error("sda pulled while unpowered");
    property p_wr_one; o_wr_en |=> !o_wr_en [*8]; endproperty
    a_wr_one: assert property (p_wr_one) else $error("write strobe too long");
    property p_wr_bump; o_wr_en |-> o_reg_index == o_wr_addr + 8'h01; endproperty
    a_wr_bump: assert property (p_wr_bump) else $error("pointer not bumped on write");
    property p_wr_ack; o_wr_en |-> ##[0:1] o_sda_oe; endproperty
    a_wr_ack: assert property (p_wr_ack) else $error("write byte not acked");
    // any change besides a load at an ack is a plain wrapping step
    property p_step;
        $changed(o_reg_index) && !$rose(o_sda_oe) |-> o_reg_index == $past(o_reg_index) + 8'h01;
    endproperty
    a_step: assert property (p_step) else $error("pointer jumped");
    property p_edge; $changed(o_sda_oe) |-> !i_scl; endproperty
    a_edge: assert property (p_edge) else $error("sda moved while scl high");
    property p_stands; $rose(o_sda_oe) |=> o_sda_oe [*2]; endproperty
    a_stands: assert property (p_stands) else $error("sda drive glitch");
    property p_zero; o_sda_out == 1'b0; endproperty
    a_zero: assert property (p_zero) else $error("sda driven high");
endmodule
bind i2crt_target i2crt_target_sva u_i2crt_target_sva (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_bias_rails_good(i_bias_rails_good), .i_scl(i_scl), .o_sda_oe(o_sda_oe),
    .o_sda_out(o_sda_out), .o_reg_index(o_reg_index), .o_wr_en(o_wr_en), .o_wr_addr(o_wr_addr));

// [tb/i2crt_host_model.sv]
/* i2c host model: drives scl and its share of sda at clock edges.
   assumes a pull-up bus: i_sda is the resolved wire level. */
`timescale 1ns/10ps
module i2crt_host_model (
    input  wire i_clk,
    input  wire i_sda,
    output reg  o_scl = 1'b1,
    output reg  o_sda = 1'b1
);
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    task automatic start();
        o_sda <= 1'b1;
        tick(2);
        o_scl <= 1'b1;
        tick(4);
        o_sda <= 1'b0;
        tick(4);
        o_scl <= 1'b0;
        tick(2);
    endtask
    // stop ends a read after nack
    task automatic stop();
        o_sda <= 1'b0;
        tick(4);
        o_scl <= 1'b1;
        tick(4);
        o_sda <= 1'b1;
        tick(4);
    endtask
    // msb first, n bits; a one releases sda so the target may answer
    task automatic bits(input [8:0] tx, input int n, output [8:0] rx);
        int i;
        rx = 9'h000;
        for (i = 8; i > 8 - n; i--) begin
            o_sda <= tx[i];
            tick(4);
            o_scl <= 1'b1;
            tick(2);
            rx[i] = i_sda;
            tick(2);
            o_scl <= 1'b0;
            tick(4);
        end
    endtask
endmodule

// [tb/i2crt_target_tb_top.sv]
/* bench for the i2c target: host model on the bus, register file beside.
   assumes the checker is bound from its own file. */
`timescale 1ns/10ps
`define CHECK(what, exp, got) begin num_checks++; if ((got) !== (exp)) begin failures++; \
    $display("ERROR %s exp %h got %h", what, exp, got); end end
module i2crt_target_tb_top;
    reg         i_clk = 1'b0;
    reg         rst_n = 1'b0;
    reg         bias = 1'b0;
    reg  [2:0]  sel = 3'h0;
    wire        scl, h_sda, oe, sda_out, wr_en;
    wire [7:0]  idx, wr_addr, wr_data;
    wire        sda = h_sda & ~oe;        // pull-up wire
    reg  [7:0]  regs [0:255];             // register file beside the target
    reg  [7:0]  exp_mem [0:255];
    reg  [15:0] wr_q [$];
    reg  [7:0]  rd_q [$];
    reg  [15:0] note;
    reg  [7:0]  rd_byte, ab;
    reg  [8:0]  junk;
    reg  [31:0] seed = 32'ha9c2ff50;
    int         failures = 0, num_checks = 0, k;
    event       rd_ev;
    always #12.5 i_clk = ~i_clk;
    always @(posedge i_clk) if (wr_en) regs[wr_addr] <= wr_data;
    i2crt_target #(.PTR_W(8)) u_i2crt_target (.i_clk(i_clk), .i_resetn(rst_n),
        .i_bias_rails_good(bias), .i_addr_sel(sel), .i_scl(scl), .i_sda(sda),
        .i_rd_data(regs[idx]), .o_sda_oe(oe), .o_sda_out(sda_out), .o_reg_index(idx),
        .o_wr_en(wr_en), .o_wr_addr(wr_addr), .o_wr_data(wr_data));
    i2crt_host_model u_i2crt_host_model (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda(h_sda));
    ////////////////////////////////////////////////////////////////////////////
    // results taken oldest note first
    always @(posedge i_clk) if (wr_en === 1'b1) begin
        note = wr_q.pop_front();
        `CHECK("write", note, {wr_addr, wr_data})
    end
    always @(rd_ev) begin
        note = {8'h00, rd_q.pop_front()};
        `CHECK("read", note[7:0], rd_byte)
    end
    function automatic [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic put(input [7:0] b, input bit want);
        reg [8:0] rx;
        u_i2crt_host_model.bits({b, 1'b1}, 9, rx);
        `CHECK("ack", want, ~rx[0])
    endtask
    // index byte, then n data bytes with bit 2 set so an early stop can pass
    task automatic wr_burst(input [7:0] a, input int n);
        u_i2crt_host_model.start();
        put(8'h10, 1'b1);
        put(a, 1'b1);
        repeat (n) begin
            seed = lfsr(seed);
            exp_mem[a] = seed[7:0] | 8'h04;
            wr_q.push_back({a, exp_mem[a]});
            put(exp_mem[a], 1'b1);
            a = a + 8'h01;
        end
    endtask
    task automatic rd_burst(input [7:0] a, input int n);
        reg [8:0] rx;
        u_i2crt_host_model.start();
        put(8'h11, 1'b1);
        for (int j = 0; j < n; j++) begin
            rd_q.push_back(exp_mem[a]);
            u_i2crt_host_model.bits({8'hff, j == n - 1}, 9, rx);
            rd_byte = rx[8:1];
            -> rd_ev;
            a = a + 8'h01;
        end
        u_i2crt_host_model.stop();
    endtask
    task automatic summarize();
        if (failures == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #1000000;
        failures++;
        summarize();
    end
    initial begin
        repeat (2) @(posedge i_clk);
        rst_n <= 1'b1;
        bias <= 1'b1;
        repeat (4) @(posedge i_clk);
        `CHECK("index", 8'h00, idx)
        wr_burst(8'h3c, 3);
        u_i2crt_host_model.stop();
        // index rewritten before a single read
        wr_burst(8'h3c, 0);
        rd_burst(8'h3c, 1);
        u_i2crt_host_model.start();
        put(8'h22, 1'b0);
        u_i2crt_host_model.stop();
        `CHECK("index", 8'h3d, idx)
        rd_burst(8'h3d, 1);
        wr_burst(8'hfe, 4);
        u_i2crt_host_model.stop();
        wr_burst(8'hfe, 0);
        rd_burst(8'hfe, 3);
        `CHECK("index", 8'h01, idx)
        wr_burst(8'h3c, 0);
        u_i2crt_host_model.start();
        put(8'h11, 1'b1);
        u_i2crt_host_model.bits(9'h1ff, 4, junk);
        `CHECK("index", 8'h3c, idx)
        u_i2crt_host_model.bits(9'h1ff, 1, junk);
        u_i2crt_host_model.stop();
        `CHECK("index", 8'h3d, idx)
        bias <= 1'b0;
        // no ack and no index load while unpowered
        u_i2crt_host_model.start();
        put(8'h10, 1'b0);
        put(8'h50, 1'b0);
        u_i2crt_host_model.stop();
        `CHECK("index", 8'h3d, idx)
        // codes 6 and 7 act as the top option
        for (k = 0; k < 8; k++) begin
            bias <= 1'b0;
            sel <= k[2:0];
            @(posedge i_clk);
            bias <= 1'b1;
            repeat (2) @(posedge i_clk);
            ab = 8'h10 + {((k < 6) ? k[6:0] : 7'h05), 1'b0};
            u_i2crt_host_model.start();
            put(ab, 1'b1);
            put(ab, 1'b1);
            u_i2crt_host_model.stop();
            `CHECK("index", ab, idx)
        end
        summarize();
    end
endmodule
